// ===== dac_consts.svh
`ifndef DAC_CONSTS_SVH
`define DAC_CONSTS_SVH

`define SFR_DAC0_CONTROL 8'hB9
`define SFR_DAC0_DATA_HIGH 8'h97
`define SFR_DAC0_DATA_LOW 8'h96
`define SFR_DAC1_CONTROL 8'hB5
`define SFR_DAC1_DATA_HIGH 8'hF5
`define SFR_DAC1_DATA_LOW 8'hF4

`define CONTROL_RESET 8'h73
`define DATA_RESET 8'h00
`define CONTROL_WRITE_MASK 8'hF7

`define BIT_ENABLE 7
`define FIELD_SOURCE_HI 6
`define FIELD_SOURCE_LO 4
`define BIT_RIGHT_JUSTIFY 2
`define FIELD_RANGE_HI 1
`define FIELD_RANGE_LO 0

`define SRC_TIMER0 3'h0
`define SRC_TIMER1 3'h1
`define SRC_TIMER2 3'h2
`define SRC_TIMER3 3'h3
`define SRC_STROBE_RISE 3'h4
`define SRC_STROBE_FALL 3'h5
`define SRC_STROBE_ANY 3'h6
`define SRC_ON_DEMAND 3'h7

`endif

// ===== dac_pkg.sv
package dac_pkg;
    typedef logic [7:0] sfr_byte_t;
    typedef logic [11:0] dac_word_t;
    typedef logic [2:0] update_source_t;
    typedef logic [1:0] range_t;
endpackage

// ===== dac_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "dac_consts.svh"

module dac_channel
    import dac_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic control_write,
    input wire logic high_write,
    input wire logic low_write,
    input wire dac_pkg::sfr_byte_t write_data,
    input wire logic [3:0] timer_overflow,
    input wire logic strobe_rise,
    input wire logic strobe_fall,
    output dac_pkg::sfr_byte_t control_value,
    output dac_pkg::sfr_byte_t high_value,
    output dac_pkg::sfr_byte_t low_value,
    output dac_pkg::dac_word_t converter_word,
    output logic channel_enable,
    output dac_pkg::range_t full_scale_range
);
    import dac_pkg::*;

    typedef struct packed {
        sfr_byte_t control;
        sfr_byte_t high;
        sfr_byte_t low;
        dac_word_t latch;
    } chan_state_t;

    chan_state_t state_reg;
    chan_state_t state_next;
    update_source_t source;
    logic update_event;

    // Builds the 12-bit word from the two bytes in the chosen placement.
    function automatic dac_word_t assemble(input logic rj, input sfr_byte_t hi, input sfr_byte_t lo);
        dac_word_t w;
        if (rj)
        begin
            w = {hi[3:0], lo}; // RL11
        end
        else
        begin
            w = {hi, lo[7:4]}; // RL10
        end
        return w;
    endfunction

    assign source = state_reg.control[`FIELD_SOURCE_HI:`FIELD_SOURCE_LO];

    always_comb
    begin
        case (source)
            `SRC_TIMER0, `SRC_TIMER1, `SRC_TIMER2, `SRC_TIMER3:
                update_event = timer_overflow[source[1:0]]; // RL2 RL7
            `SRC_STROBE_RISE: update_event = strobe_rise; // RL3 RL9
            `SRC_STROBE_FALL: update_event = strobe_fall; // RL3 RL9
            `SRC_STROBE_ANY: update_event = strobe_rise | strobe_fall; // RL3 RL9
            default: update_event = high_write; // RL4 RL5
        endcase
    end

    always_comb
    begin
        logic rj;
        sfr_byte_t hi;
        sfr_byte_t lo;
        rj = state_reg.control[`BIT_RIGHT_JUSTIFY]; // RL12
        hi = state_reg.high;
        lo = state_reg.low;
        state_next = state_reg;
        if (control_write)
        begin
            state_next.control = write_data & `CONTROL_WRITE_MASK; // RL14
        end
        if (high_write)
        begin
            state_next.high = write_data;
        end
        if (low_write)
        begin
            state_next.low = write_data; // RL5
        end
        hi = state_next.high;
        lo = state_next.low;
        if (update_event)
        begin
            state_next.latch = assemble(rj, hi, lo); // RL7 RL9
        end
        if (sys_rst)
        begin
            state_next.control = `CONTROL_RESET;
            state_next.high = `DATA_RESET;
            state_next.low = `DATA_RESET;
            state_next.latch = '0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        state_reg <= state_next;
    end

    assign control_value = state_reg.control;
    // Unused nibbles read as zero in the chosen placement.
    assign high_value = state_reg.control[`BIT_RIGHT_JUSTIFY]
        ? {4'h0, state_reg.high[3:0]} : state_reg.high; // RL16
    assign low_value = state_reg.control[`BIT_RIGHT_JUSTIFY]
        ? state_reg.low : {state_reg.low[7:4], 4'h0}; // RL16
    assign converter_word = state_reg.latch;
    assign channel_enable = state_reg.control[`BIT_ENABLE]; // RL1
    assign full_scale_range = state_reg.control[`FIELD_RANGE_HI:`FIELD_RANGE_LO]; // RL13

endmodule
`default_nettype wire

// ===== current_dac_update_control.sv
// How it works
// RL1: Two 12-bit channels, each enabled by bit 7.
// RL2: Source codes 000-011 pick timers zero to three.
// RL3: Codes 100/101/110 pick strobe rise/fall/either edge.
// RL4: Code 111 default: high byte write updates.
// RL5: On-demand low write held until high write.
// RL6: Software writes low byte before high byte.
// RL7: Timer modes hold both bytes until overflow.
// RL8: Timers two/three use low or high overflow.
// RL9: Strobe modes hold bytes until selected edge.
// RL10: Left: D11-D4 high, D3-D0 low upper nibble.
// RL11: Right: D11-D8 high nibble, D7-D0 low byte.
// RL12: Control bit 2 selects right justification.
// RL13: Bits 1-0 select range, default 2 mA.
// RL14: Reserved bit 3 reads zero, written zero.
// RL15: Eight-bit use: preset low, write high only.
// RL16: Unused data nibbles read as zero.
// RL17: Either channel enabled disables pin driver, pullup.
// RL18: Strobe synchronised, edges give one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`include "dac_consts.svh"

module current_dac_update_control
    import dac_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire dac_pkg::sfr_byte_t sfr_addr,
    input wire dac_pkg::sfr_byte_t sfr_wdata,
    input wire logic sfr_write,
    input wire logic sfr_read,
    output dac_pkg::sfr_byte_t sfr_rdata,
    output logic sfr_hit,
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic timer2_low_overflow,
    input wire logic timer2_high_overflow,
    input wire logic timer2_split_8bit,
    input wire logic timer3_low_overflow,
    input wire logic timer3_high_overflow,
    input wire logic timer3_split_8bit,
    input wire logic external_convert_strobe,
    output dac_pkg::dac_word_t dac_channel_zero_word,
    output dac_pkg::dac_word_t dac_channel_one_word,
    output logic dac_channel_zero_enable,
    output logic dac_channel_one_enable,
    output dac_pkg::range_t dac_channel_zero_range,
    output dac_pkg::range_t dac_channel_one_range,
    output logic pin_driver_disable
);
    import dac_pkg::*;

    // ****************************************************************
    // Strobe synchroniser and edge detector
    // ****************************************************************
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        sfr_byte_t rdata;
        logic hit;
    } top_state_t;

    top_state_t state_reg;
    top_state_t state_next;
    logic strobe_rise;
    logic strobe_fall;
    logic [3:0] timer_overflow;
    sfr_byte_t ctl0, hi0, lo0, ctl1, hi1, lo1;

    assign strobe_rise = state_reg.sync2 & ~state_reg.prev; // RL18
    assign strobe_fall = ~state_reg.sync2 & state_reg.prev; // RL18

    // ****************************************************************
    // Timer overflow selection
    // ****************************************************************
    assign timer_overflow[0] = timer0_overflow;
    assign timer_overflow[1] = timer1_overflow;
    assign timer_overflow[2] = timer2_split_8bit ? timer2_low_overflow
        : timer2_high_overflow; // RL8
    assign timer_overflow[3] = timer3_split_8bit ? timer3_low_overflow
        : timer3_high_overflow; // RL8

    // ****************************************************************
    // Channels
    // ****************************************************************
    dac_channel u_chan0 (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .control_write(sfr_write && sfr_addr == `SFR_DAC0_CONTROL),
        .high_write(sfr_write && sfr_addr == `SFR_DAC0_DATA_HIGH),
        .low_write(sfr_write && sfr_addr == `SFR_DAC0_DATA_LOW),
        .write_data(sfr_wdata),
        .timer_overflow(timer_overflow),
        .strobe_rise(strobe_rise),
        .strobe_fall(strobe_fall),
        .control_value(ctl0),
        .high_value(hi0),
        .low_value(lo0),
        .converter_word(dac_channel_zero_word),
        .channel_enable(dac_channel_zero_enable),
        .full_scale_range(dac_channel_zero_range)
    );

    dac_channel u_chan1 (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .control_write(sfr_write && sfr_addr == `SFR_DAC1_CONTROL),
        .high_write(sfr_write && sfr_addr == `SFR_DAC1_DATA_HIGH),
        .low_write(sfr_write && sfr_addr == `SFR_DAC1_DATA_LOW),
        .write_data(sfr_wdata),
        .timer_overflow(timer_overflow),
        .strobe_rise(strobe_rise),
        .strobe_fall(strobe_fall),
        .control_value(ctl1),
        .high_value(hi1),
        .low_value(lo1),
        .converter_word(dac_channel_one_word),
        .channel_enable(dac_channel_one_enable),
        .full_scale_range(dac_channel_one_range)
    );

    assign pin_driver_disable = dac_channel_zero_enable | dac_channel_one_enable; // RL17

    // ****************************************************************
    // Register read path and state
    // ****************************************************************
    always_comb
    begin
        state_next = state_reg;
        state_next.sync1 = external_convert_strobe;
        state_next.sync2 = state_reg.sync1;
        state_next.prev = state_reg.sync2;
        state_next.hit = 1'b0;
        state_next.rdata = 8'h00;
        if (sfr_read)
        begin
            state_next.hit = 1'b1;
            case (sfr_addr)
                `SFR_DAC0_CONTROL: state_next.rdata = ctl0; // RL14
                `SFR_DAC0_DATA_HIGH: state_next.rdata = hi0;
                `SFR_DAC0_DATA_LOW: state_next.rdata = lo0;
                `SFR_DAC1_CONTROL: state_next.rdata = ctl1; // RL14
                `SFR_DAC1_DATA_HIGH: state_next.rdata = hi1;
                `SFR_DAC1_DATA_LOW: state_next.rdata = lo1;
                default: state_next.hit = 1'b0;
            endcase
        end
        if (sys_rst)
        begin
            state_next = '0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        state_reg <= state_next;
    end

    assign sfr_rdata = state_reg.rdata;
    assign sfr_hit = state_reg.hit;

endmodule
`default_nettype wire

// ===== dac_ctl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "dac_consts.svh"
module dac_ctl_asserts
    import dac_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire dac_pkg::sfr_byte_t sfr_addr,
    input wire dac_pkg::sfr_byte_t sfr_wdata,
    input wire logic sfr_write,
    input wire logic sfr_read,
    input wire dac_pkg::sfr_byte_t sfr_rdata,
    input wire logic sfr_hit,
    input wire logic timer0_overflow,
    input wire logic timer2_low_overflow,
    input wire logic timer2_split_8bit,
    input wire dac_pkg::dac_word_t dac_channel_zero_word,
    input wire logic dac_channel_zero_enable,
    input wire logic dac_channel_one_enable,
    input wire dac_pkg::range_t dac_channel_zero_range,
    input wire logic pin_driver_disable
);
    // Shadow copies of the channel zero control and low byte, tracked from writes.
    sfr_byte_t ctl_reg;
    sfr_byte_t low_reg;
    update_source_t mode;
    assign mode = ctl_reg[`FIELD_SOURCE_HI:`FIELD_SOURCE_LO];
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            ctl_reg <= `CONTROL_RESET;
            low_reg <= `DATA_RESET;
        end
        else if (sfr_write && sfr_addr == `SFR_DAC0_CONTROL)
            ctl_reg <= sfr_wdata & `CONTROL_WRITE_MASK;
        else if (sfr_write && sfr_addr == `SFR_DAC0_DATA_LOW)
            low_reg <= sfr_wdata;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_reserved_reads_zero: assert property (
        sfr_read && sfr_addr == `SFR_DAC0_CONTROL |=> sfr_hit && !sfr_rdata[3])
        else $error("Control read returned bit 3 set.");
    a_enable_from_write: assert property (
        sfr_write && sfr_addr == `SFR_DAC0_CONTROL
        |=> dac_channel_zero_enable == $past(sfr_wdata[7]))
        else $error("Channel enable does not follow control bit 7.");
    a_range_from_write: assert property (
        sfr_write && sfr_addr == `SFR_DAC0_CONTROL
        |=> dac_channel_zero_range == $past(sfr_wdata[1:0]))
        else $error("Range does not follow control bits 1 to 0.");
    a_pin_driver_off: assert property (
        pin_driver_disable == (ctl_reg[`BIT_ENABLE] || dac_channel_one_enable))
        else $error("Pin driver disable is not the OR of the enables.");
    a_on_demand_load: assert property (
        mode == `SRC_ON_DEMAND && sfr_write && sfr_addr == `SFR_DAC0_DATA_HIGH
        |=> dac_channel_zero_word == (ctl_reg[`BIT_RIGHT_JUSTIFY] ? {$past(sfr_wdata[3:0]), low_reg}
            : {$past(sfr_wdata), low_reg[7:4]}))
        else $error("High byte write did not load the expected word.");
    a_low_write_held: assert property (
        mode == `SRC_ON_DEMAND && sfr_write && sfr_addr == `SFR_DAC0_DATA_LOW
        |=> $stable(dac_channel_zero_word))
        else $error("Low byte write changed the word.");
    a_timer0_held: assert property (
        mode == `SRC_TIMER0 && !timer0_overflow |=> $stable(dac_channel_zero_word))
        else $error("Word changed without a timer 0 overflow.");
    a_timer2_low_select: assert property (
        mode == `SRC_TIMER2 && timer2_split_8bit && !timer2_low_overflow
        |=> $stable(dac_channel_zero_word))
        else $error("Word changed without a timer 2 low overflow.");
    c_on_demand: cover property (mode == `SRC_ON_DEMAND && sfr_write
        && sfr_addr == `SFR_DAC0_DATA_HIGH);
    c_timer0: cover property (mode == `SRC_TIMER0 && timer0_overflow);
    c_timer2: cover property (mode == `SRC_TIMER2 && timer2_low_overflow);
endmodule
bind current_dac_update_control dac_ctl_asserts chk_u (.ref_clk, .sys_rst, .sfr_addr,
    .sfr_wdata, .sfr_write, .sfr_read, .sfr_rdata, .sfr_hit, .timer0_overflow,
    .timer2_low_overflow, .timer2_split_8bit, .dac_channel_zero_word,
    .dac_channel_zero_enable, .dac_channel_one_enable, .dac_channel_zero_range,
    .pin_driver_disable);
`default_nettype wire

// ===== current_dac_update_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dac_consts.svh"
module current_dac_update_control_tb;
    import dac_pkg::*;
    logic ref_clk = 0, sys_rst = 1, sfr_write = 0, sfr_read = 0, strobe = 0;
    logic t2_split = 1, t3_split = 0, sfr_hit, en0, en1, pin_off;
    logic [5:0] tp = 0;
    logic [5:0] wrong [4] = '{6'h02, 6'h01, 6'h08, 6'h10};
    logic [5:0] right [4] = '{6'h01, 6'h02, 6'h04, 6'h20};
    sfr_byte_t sfr_addr = 0, sfr_wdata = 0, sfr_rdata;
    dac_word_t w0, w1, e;
    range_t r0, r1;
    int errors = 0, comparisons = 0, cyc = 0;
    always #10 ref_clk = ~ref_clk;
    current_dac_update_control dut_u (.ref_clk, .sys_rst, .sfr_addr, .sfr_wdata, .sfr_write,
        .sfr_read, .sfr_rdata, .sfr_hit, .timer0_overflow(tp[0]), .timer1_overflow(tp[1]),
        .timer2_low_overflow(tp[2]), .timer2_high_overflow(tp[3]), .timer2_split_8bit(t2_split),
        .timer3_low_overflow(tp[4]), .timer3_high_overflow(tp[5]), .timer3_split_8bit(t3_split),
        .external_convert_strobe(strobe), .dac_channel_zero_word(w0), .dac_channel_one_word(w1),
        .dac_channel_zero_enable(en0), .dac_channel_one_enable(en1), .dac_channel_zero_range(r0),
        .dac_channel_one_range(r1), .pin_driver_disable(pin_off));
    task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input sfr_byte_t a, input sfr_byte_t d);
        @(negedge ref_clk);
        sfr_write = 1;
        sfr_addr = a;
        sfr_wdata = d;
        @(negedge ref_clk);
        sfr_write = 0;
    endtask
    task automatic rd(input sfr_byte_t a, input sfr_byte_t x, input logic h);
        @(negedge ref_clk);
        sfr_read = 1;
        sfr_addr = a;
        @(negedge ref_clk);
        sfr_read = 0;
        chk("read data", 12'(sfr_rdata), 12'(x));
        chk("read hit", 12'(sfr_hit), 12'(h));
    endtask
    task automatic pulse(input logic [5:0] p);
        @(negedge ref_clk);
        tp = p;
        @(negedge ref_clk);
        tp = 0;
        repeat (2) @(negedge ref_clk);
    endtask
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            errors++;
            end_sim();
        end
    end
    // ************************************************
    // Main sequence.
    // ************************************************
    initial
    begin
        repeat (20) @(negedge ref_clk);
        sys_rst = 0;
        rd(`SFR_DAC0_CONTROL, `CONTROL_RESET, 1);
        rd(`SFR_DAC1_DATA_HIGH, `DATA_RESET, 1);
        rd(8'h00, 8'h00, 0);
        chk("range zero", 12'(r0), 12'h3);
        wr(`SFR_DAC0_CONTROL, 8'hFF);
        rd(`SFR_DAC0_CONTROL, `CONTROL_WRITE_MASK, 1);
        chk("enable zero", 12'(en0), 12'h1);
        chk("enable one", 12'(en1), 12'h0);
        chk("pin driver", 12'(pin_off), 12'h1);
        for (int r = 0; r < 4; r++)
        begin
            wr(`SFR_DAC1_CONTROL, 8'h70 | 8'(r));
            chk("range one", 12'(r1), 12'(r));
        end
        wr(`SFR_DAC0_CONTROL, 8'hF3);
        wr(`SFR_DAC0_DATA_LOW, 8'h5F);
        @(negedge ref_clk);
        chk("low held", w0, 12'h000);
        wr(`SFR_DAC0_DATA_HIGH, 8'hAB);
        @(negedge ref_clk);
        chk("on demand", w0, 12'hAB5);
        wr(`SFR_DAC0_DATA_HIGH, 8'hCD);
        @(negedge ref_clk);
        chk("eight bit", w0, 12'hCD5);
        rd(`SFR_DAC0_DATA_LOW, 8'h50, 1);
        wr(`SFR_DAC1_CONTROL, 8'hF4);
        wr(`SFR_DAC1_DATA_LOW, 8'h34);
        wr(`SFR_DAC1_DATA_HIGH, 8'hF2);
        @(negedge ref_clk);
        chk("right justify", w1, 12'h234);
        rd(`SFR_DAC1_DATA_HIGH, 8'h02, 1);
        e = 12'hCD5;
        for (int k = 0; k < 6; k++)
        begin
            int m;
            m = (k < 4) ? k : k - 2;
            if (k == 4)
            begin
                t2_split = 0;
                t3_split = 1;
            end
            wr(`SFR_DAC0_CONTROL, 8'h83 | 8'(m << 4));
            wr(`SFR_DAC0_DATA_LOW, 8'(m << 4));
            wr(`SFR_DAC0_DATA_HIGH, 8'hC0 | 8'(m));
            pulse((k < 4) ? wrong[m] : right[m]);
            chk("timer held", w0, e);
            pulse((k < 4) ? right[m] : wrong[m]);
            e = {8'hC0 | 8'(m), 4'(m)};
            chk("timer update", w0, e);
        end
        e = 12'h234;
        for (int m = 4; m < 7; m++)
        begin
            wr(`SFR_DAC1_CONTROL, 8'h83 | 8'(m << 4));
            wr(`SFR_DAC1_DATA_HIGH, 8'(m));
            strobe = 1;
            repeat (6) @(negedge ref_clk);
            if (m != 5)
                e = {8'(m), 4'h3};
            chk("strobe rise", w1, e);
            wr(`SFR_DAC1_DATA_HIGH, 8'(m + 8));
            strobe = 0;
            repeat (6) @(negedge ref_clk);
            if (m != 4)
                e = {8'(m + 8), 4'h3};
            chk("strobe fall", w1, e);
        end
        wr(`SFR_DAC0_CONTROL, 8'h73);
        wr(`SFR_DAC1_CONTROL, 8'h73);
        chk("pin released", 12'(pin_off), 12'h0);
        end_sim();
    end
endmodule
`default_nettype wire
